// ===== ncu_pkg.sv
// package: command codes, register map and timing for the nand host controller
`default_nettype none
package ncu_pkg;
  // command bytes written to the flash
  localparam logic [7:0] CMD_READ_SETUP = 8'h00;
  localparam logic [7:0] CMD_READ_START = 8'h30;
  localparam logic [7:0] CMD_DATA_IN = 8'h80;
  localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_ID_READ = 8'h90;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  // operation codes written by software to the control register
  localparam logic [2:0] OP_READ = 3'h1;
  localparam logic [2:0] OP_PROG = 3'h2;
  localparam logic [2:0] OP_ERASE = 3'h3;
  localparam logic [2:0] OP_ID = 3'h4;
  localparam logic [2:0] OP_STATUS = 3'h5;
  localparam logic [2:0] OP_RESET = 3'h6;
  // register word addresses (avalon word address)
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_COLUMN = 3'h1;
  localparam logic [2:0] ADDR_PAGE = 3'h2;
  localparam logic [2:0] ADDR_COUNT = 3'h3;
  localparam logic [2:0] ADDR_WDATA = 3'h4;
  localparam logic [2:0] ADDR_RDATA = 3'h5;
  localparam logic [2:0] ADDR_STATUS = 3'h6;
  localparam logic [2:0] ADDR_IDLO = 3'h7;
  // status byte bit positions
  localparam int ST_FAIL = 0;
  localparam int ST_READY = 5;
  localparam int ST_WP_N = 7;
  // id layout: number of identification bytes
  localparam logic [2:0] ID_BYTES = 3'h5;
  // strobe phase length in ns and in cycles at 25 MHz
  localparam int CLK_MHZ = 25;
  localparam int STROBE_NS = 50;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  // wait after a read-start, confirm or reset command for the busy line to fall
  localparam int BUSY_WAIT_NS = 200;
  localparam int BUSY_WAIT_CYC = (BUSY_WAIT_NS * CLK_MHZ + 999) / 1000;
endpackage : ncu_pkg
`default_nettype wire

// ===== ncu_ctrl.sv
// file: host controller that drives a byte-wide nand flash over its pins
//
// The implementer's own choices: the Avalon-MM register port and the register addresses.
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module ncu_ctrl
  import ncu_pkg::*;
#(
  parameter int COUNT_W = 12
)
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // avalon-mm slave
  input wire logic [2:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // flash strobes
  output logic CMD_LATCH,
  output logic ADDR_LATCH,
  output logic CHIP_EN_N,
  output logic WRITE_STROBE_N,
  output logic READ_STROBE_N,
  output logic WRITE_PROT_N,
  // byte port as input, output and enable
  input wire logic [7:0] BYTE_PORT_IN,
  output logic [7:0] BYTE_PORT_OUT,
  output logic BYTE_PORT_OE,
  // open-drain done line from the flash
  input wire logic DONE_LINE_N
);
  typedef enum logic [7:0] {
    S_IDLE = 8'h01, S_CMD1 = 8'h02, S_ADDR = 8'h04, S_DATA = 8'h08,
    S_CMD2 = 8'h10, S_WAIT = 8'h20, S_RDATA = 8'h40, S_DONE = 8'h80
  } ncu_state_type;

  // strobe sequencer: one byte cycle is a low phase then a high phase
  typedef enum logic [1:0] {
    P_LOW = 2'h1, P_HIGH = 2'h2
  } ncu_phase_type;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  ncu_state_type state_reg, state_next;
  ncu_phase_type phase_reg;
  logic [2:0] op_reg;
  logic [11:0] column_reg;
  logic [15:0] page_reg;
  logic [COUNT_W-1:0] count_reg;
  logic [COUNT_W-1:0] left_reg;
  logic [2:0] aidx_reg;
  logic [7:0] tick_reg;
  logic [7:0] wdata_reg;
  logic wdata_full_reg;
  logic [7:0] rdata_reg;
  logic rdata_full_reg;
  logic [7:0] status_reg;
  logic [31:0] id_reg;
  logic [7:0] id5_reg;
  logic wp_n_reg;
  logic busy_reg;
  logic abort_reg;
  logic [7:0] dout_reg;
  logic cle_reg, ale_reg, we_n_reg, re_n_reg, oe_reg;
  logic done_s1_reg, done_s2_reg;
  logic [7:0] din_s1_reg, din_s2_reg;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers
  function automatic logic [7:0] first_cmd(input logic [2:0] op);
    case (op)
      OP_READ: first_cmd = CMD_READ_SETUP;
      OP_PROG: first_cmd = CMD_DATA_IN;
      OP_ERASE: first_cmd = CMD_ERASE_SETUP;
      OP_ID: first_cmd = CMD_ID_READ;
      OP_STATUS: first_cmd = CMD_STATUS;
      default: first_cmd = CMD_RESET;
    endcase
  endfunction : first_cmd

  // address bytes needed per operation
  function automatic logic [2:0] addr_len(input logic [2:0] op);
    case (op)
      OP_READ, OP_PROG: addr_len = 3'h4;
      OP_ERASE: addr_len = 3'h2;
      OP_ID: addr_len = 3'h1;
      default: addr_len = 3'h0;
    endcase
  endfunction : addr_len

  ////////////////////////////////////////////////////////////////////////////
  // wires
  wire done_ready = done_s2_reg;
  // the phase timer only paces strobes; in the wait state it counts on
  wire phase_end = (state_reg != S_WAIT)
    && (tick_reg == 8'(STROBE_CYC - 1));
  wire byte_done = phase_end && (phase_reg == P_HIGH);
  wire ctrl_wr = AVS_WRITE && (AVS_ADDRESS == ADDR_CTRL);
  wire start = ctrl_wr && (state_reg == S_IDLE);
  wire abort_bus = ctrl_wr && (AVS_WRITEDATA[2:0] == OP_RESET);
  // byte slot not ready: the strobe waits at the start of its low phase
  wire slot_wait = (state_reg == S_DATA && !wdata_full_reg)
    || (state_reg == S_RDATA && op_reg == OP_READ && rdata_full_reg);
  // a pending abort is applied only between strobe pulses
  wire cut_ok = byte_done || slot_wait || state_reg == S_IDLE
    || state_reg == S_WAIT || state_reg == S_DONE;
  wire abort = abort_reg && cut_ok;
  wire wdata_wr = AVS_WRITE && (AVS_ADDRESS == ADDR_WDATA);
  wire rdata_rd = AVS_READ && (AVS_ADDRESS == ADDR_RDATA);
  // stall writes to a full data slot and reads of an empty one
  wire stall = (wdata_wr && wdata_full_reg) || (rdata_rd && !rdata_full_reg)
    || (ctrl_wr && state_reg != S_IDLE && !abort_bus);
  wire [7:0] addr_byte = (aidx_reg == 3'h0) ?
    ((op_reg == OP_ERASE) ? page_reg[7:0] :
     (op_reg == OP_ID) ? 8'h00 : column_reg[7:0]) :
    (aidx_reg == 3'h1) ?
    ((op_reg == OP_ERASE) ? page_reg[15:8] : {4'h0, column_reg[11:8]}) :
    (aidx_reg == 3'h2) ? page_reg[7:0] : page_reg[15:8];
  wire needs_data = (op_reg == OP_PROG) && left_reg != '0;
  wire reads_data = (op_reg == OP_READ || op_reg == OP_ID
    || op_reg == OP_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // state transitions
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: if (start) state_next = S_CMD1;
      S_CMD1:
        if (byte_done)
          state_next = (addr_len(op_reg) != 3'h0) ? S_ADDR :
            (op_reg == OP_STATUS) ? S_RDATA : S_WAIT;
      S_ADDR:
        if (byte_done && aidx_reg == addr_len(op_reg) - 3'h1)
          state_next = needs_data ? S_DATA :
            (op_reg == OP_ID) ? S_RDATA : S_CMD2;
      S_DATA:
        if (byte_done && left_reg == COUNT_W'(1)) state_next = S_CMD2;
      S_CMD2: if (byte_done) state_next = S_WAIT;
      S_WAIT:
        if (tick_reg >= 8'(BUSY_WAIT_CYC) && done_ready)
          state_next = reads_data && left_reg != '0 ? S_RDATA : S_DONE;
      S_RDATA:
        if (byte_done && left_reg == COUNT_W'(1)) state_next = S_DONE;
      S_DONE: state_next = S_IDLE;
      default: state_next = S_IDLE;
    endcase
    if (abort) state_next = S_CMD1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  always_ff @(posedge REF_CLK)
  begin
    done_s1_reg <= DONE_LINE_N;
    done_s2_reg <= done_s1_reg;
    din_s1_reg <= BYTE_PORT_IN;
    din_s2_reg <= din_s1_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer, strobes and data movement
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      state_reg <= S_IDLE;
      phase_reg <= P_LOW;
      tick_reg <= 8'h00;
      op_reg <= OP_RESET;
      aidx_reg <= 3'h0;
      left_reg <= '0;
      busy_reg <= 1'b0;
      abort_reg <= 1'b0;
      cle_reg <= 1'b0;
      ale_reg <= 1'b0;
      we_n_reg <= 1'b1;
      re_n_reg <= 1'b1;
      oe_reg <= 1'b0;
      dout_reg <= 8'h00;
      rdata_reg <= 8'h00;
      rdata_full_reg <= 1'b0;
      wdata_full_reg <= 1'b0;
      status_reg <= 8'h00;
      id_reg <= 32'h0000_0000;
      id5_reg <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      // remember an abort until the current strobe pulse has finished
      if (abort_bus && state_reg != S_IDLE)
        abort_reg <= 1'b1;
      else if (abort)
        abort_reg <= 1'b0;
      // phase timer restarts on every state change
      if (state_next != state_reg || phase_end)
        tick_reg <= 8'h00;
      else if (tick_reg != 8'hFF && !slot_wait)
        tick_reg <= tick_reg + 8'h01;
      if (state_next != state_reg)
        phase_reg <= P_LOW;
      else if (phase_end)
        phase_reg <= (phase_reg == P_LOW) ? P_HIGH : P_LOW;
      if (wdata_wr && !wdata_full_reg)
        wdata_full_reg <= 1'b1;
      if (rdata_rd && rdata_full_reg)
        rdata_full_reg <= 1'b0;
      case (state_reg)
        S_IDLE:
        begin
          busy_reg <= 1'b0;
          if (start)
          begin
            op_reg <= AVS_WRITEDATA[2:0];
            aidx_reg <= 3'h0;
            left_reg <= count_reg;
            busy_reg <= 1'b1;
            if (AVS_WRITEDATA[2:0] == OP_ID) left_reg <= COUNT_W'(ID_BYTES);
            if (AVS_WRITEDATA[2:0] == OP_STATUS) left_reg <= COUNT_W'(1);
          end
        end
        S_CMD1, S_CMD2:
        begin
          // latch high, byte taken on write strobe rise
          cle_reg <= 1'b1;
          ale_reg <= 1'b0;
          oe_reg <= 1'b1;
          dout_reg <= (state_reg == S_CMD1) ? first_cmd(op_reg) :
            (op_reg == OP_ERASE) ? CMD_ERASE_CONFIRM :
            (op_reg == OP_PROG) ? CMD_PROG_CONFIRM : CMD_READ_START;
          we_n_reg <= (phase_reg == P_LOW) ? 1'b0 : 1'b1;
          if (abort) op_reg <= OP_RESET;
        end
        S_ADDR:
        begin
          cle_reg <= 1'b0;
          ale_reg <= 1'b1;
          oe_reg <= 1'b1;
          dout_reg <= addr_byte;
          we_n_reg <= (phase_reg == P_LOW) ? 1'b0 : 1'b1;
          if (byte_done) aidx_reg <= aidx_reg + 3'h1;
          if (abort) op_reg <= OP_RESET;
        end
        S_DATA:
        begin
          cle_reg <= 1'b0;
          ale_reg <= 1'b0;
          oe_reg <= 1'b1;
          dout_reg <= wdata_reg;
          // hold the strobe high until software has supplied the byte
          we_n_reg <= (phase_reg == P_LOW && wdata_full_reg) ? 1'b0 : 1'b1;
          if (byte_done)
          begin
            left_reg <= left_reg - COUNT_W'(1);
            wdata_full_reg <= 1'b0;
          end
          if (abort) op_reg <= OP_RESET;
        end
        S_WAIT:
        begin
          cle_reg <= 1'b0;
          ale_reg <= 1'b0;
          oe_reg <= 1'b0;
          we_n_reg <= 1'b1;
          if (abort) op_reg <= OP_RESET;
        end
        S_RDATA:
        begin
          oe_reg <= 1'b0;
          cle_reg <= 1'b0;
          ale_reg <= 1'b0;
          // in a page read each low pulse advances the device column
          re_n_reg <= (phase_reg == P_LOW && !slot_wait) ? 1'b0 : 1'b1;
          if (byte_done)
          begin
            left_reg <= left_reg - COUNT_W'(1);
            if (op_reg == OP_STATUS)
              status_reg <= din_s2_reg;
            else if (op_reg == OP_ID)
            begin
              // first four bytes fill the word, the fifth has its own byte
              if (left_reg == COUNT_W'(1))
                id5_reg <= din_s2_reg;
              else
                id_reg <= {id_reg[23:0], din_s2_reg};
            end
            else
            begin
              rdata_reg <= din_s2_reg;
              rdata_full_reg <= 1'b1;
            end
          end
          if (abort) op_reg <= OP_RESET;
        end
        default:
        begin
          cle_reg <= 1'b0;
          ale_reg <= 1'b0;
          oe_reg <= 1'b0;
          we_n_reg <= 1'b1;
          re_n_reg <= 1'b1;
        end
      endcase
      // abort: send the reset command next and drop stale byte slots
      if (abort)
      begin
        op_reg <= OP_RESET;
        busy_reg <= 1'b1;
        wdata_full_reg <= wdata_wr && !wdata_full_reg;
        if (!byte_done) rdata_full_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software-written setup registers
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      column_reg <= 12'h000;
      page_reg <= 16'h0000;
      count_reg <= COUNT_W'(1);
      wdata_reg <= 8'h00;
      wp_n_reg <= 1'b0;
    end
    else if (AVS_WRITE && !stall)
    begin
      case (AVS_ADDRESS)
        ADDR_COLUMN: column_reg <= AVS_WRITEDATA[11:0];
        ADDR_PAGE: page_reg <= AVS_WRITEDATA[15:0];
        ADDR_COUNT: count_reg <= AVS_WRITEDATA[COUNT_W-1:0];
        ADDR_WDATA: wdata_reg <= AVS_WRITEDATA[7:0];
        ADDR_STATUS: wp_n_reg <= AVS_WRITEDATA[ST_WP_N];
        default: wp_n_reg <= wp_n_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus read mux and pin outputs
  always_comb
  begin
    case (AVS_ADDRESS)
      ADDR_CTRL: AVS_READDATA = {28'h0, busy_reg, op_reg};
      ADDR_COLUMN: AVS_READDATA = {20'h0, column_reg};
      ADDR_PAGE: AVS_READDATA = {16'h0, page_reg};
      ADDR_COUNT: AVS_READDATA = 32'(count_reg);
      ADDR_RDATA: AVS_READDATA = {24'h0, rdata_reg};
      ADDR_STATUS: AVS_READDATA = {id5_reg, 7'h0, wp_n_reg, 7'h0,
        done_ready, status_reg};
      ADDR_IDLO: AVS_READDATA = id_reg;
      default: AVS_READDATA = {24'h0, id5_reg};
    endcase
  end
  assign AVS_WAITREQUEST = stall;
  assign CMD_LATCH = cle_reg;
  assign ADDR_LATCH = ale_reg;
  assign CHIP_EN_N = !busy_reg;
  assign WRITE_STROBE_N = we_n_reg;
  assign READ_STROBE_N = re_n_reg;
  assign WRITE_PROT_N = wp_n_reg;
  assign BYTE_PORT_OUT = dout_reg;
  assign BYTE_PORT_OE = oe_reg;
endmodule : ncu_ctrl
`default_nettype wire

// ===== ncu_ctrl_props.sv
// checker: pin and bus timing assertions for the nand host controller
`default_nettype none
module ncu_ctrl_props
  import ncu_pkg::*;
(
  // clock, reset and bus
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [2:0] AVS_ADDRESS,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic AVS_WAITREQUEST,
  // flash pins
  input wire logic CMD_LATCH,
  input wire logic ADDR_LATCH,
  input wire logic CHIP_EN_N,
  input wire logic WRITE_STROBE_N,
  input wire logic READ_STROBE_N,
  input wire logic [7:0] BYTE_PORT_OUT,
  input wire logic BYTE_PORT_OE
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // control write asking for the abort command
  wire logic abort_req;
  assign abort_req = AVS_WRITE && AVS_ADDRESS == ADDR_CTRL
    && AVS_WRITEDATA[2:0] == OP_RESET;
  // byte and latches held through the strobe rise
  property p_latch_hold;
    $rose(WRITE_STROBE_N) |-> BYTE_PORT_OE && $stable(CMD_LATCH)
      && $stable(ADDR_LATCH) && $stable(BYTE_PORT_OUT);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("byte or latch moved at strobe rise");
  property p_latch_excl;
    !(CMD_LATCH && ADDR_LATCH);
  endproperty
  a_latch_excl: assert property (p_latch_excl)
    else $error("both latches high");
  property p_we_width;
    $fell(WRITE_STROBE_N) |=> !WRITE_STROBE_N ##1 WRITE_STROBE_N[*2];
  endproperty
  a_we_width: assert property (p_we_width)
    else $error("write strobe phase length wrong");
  property p_rd_width;
    $fell(READ_STROBE_N) |=> !READ_STROBE_N ##1 READ_STROBE_N[*2];
  endproperty
  a_rd_width: assert property (p_rd_width)
    else $error("read strobe phase length wrong");
  property p_no_fight;
    !READ_STROBE_N |-> !BYTE_PORT_OE && WRITE_STROBE_N;
  endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("port driven during read strobe");
  property p_idle_quiet;
    CHIP_EN_N |-> WRITE_STROBE_N && READ_STROBE_N;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("strobe while chip disabled");
  property p_abort_taken;
    abort_req |-> !AVS_WAITREQUEST;
  endproperty
  a_abort_taken: assert property (p_abort_taken)
    else $error("abort request stalled");
  property p_abort_sent;
    abort_req && !AVS_WAITREQUEST |-> ##[1:40]
      (CMD_LATCH && !WRITE_STROBE_N && BYTE_PORT_OUT == CMD_RESET);
  endproperty
  a_abort_sent: assert property (p_abort_sent)
    else $error("abort command byte not sent");
endmodule : ncu_ctrl_props
bind ncu_ctrl ncu_ctrl_props u_props (.REF_CLK, .RST, .AVS_ADDRESS,
  .AVS_WRITE, .AVS_WRITEDATA, .AVS_WAITREQUEST, .CMD_LATCH, .ADDR_LATCH,
  .CHIP_EN_N, .WRITE_STROBE_N, .READ_STROBE_N, .BYTE_PORT_OUT,
  .BYTE_PORT_OE);
`default_nettype wire

// ===== ncu_flash_model.sv
// model: behavioural byte-wide nand flash seen from its pins
`default_nettype none
module ncu_flash_model
  import ncu_pkg::*;
#(
  parameter logic [7:0] ID0 = 8'h5A, // arbitrary value
  parameter logic [7:0] ID1 = 8'hC3, // arbitrary value
  parameter logic [7:0] ID2 = 8'h01,
  parameter logic [7:0] ID3 = 8'h26,
  parameter logic [7:0] ID4 = 8'h34,
  parameter int READ_NS = 400,
  parameter int PROG_NS = 2000,
  parameter int ERASE_NS = 20000
)
(
  // pins from the host
  input wire logic chip_en_n,
  input wire logic cmd_latch,
  input wire logic addr_latch,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic write_prot_n,
  input wire logic [7:0] byte_port,
  // answers
  output var logic [7:0] byte_drive,
  output var logic done_line_n,
  input wire logic fail_en
);
  timeunit 1ns;
  timeprecision 1ps;
  typedef enum logic [2:0] {M_IDLE, M_READ, M_PROG, M_ID, M_STAT}
    ncu_mode_type;
  ncu_mode_type mode = M_IDLE;
  logic [7:0] mem [0:63];
  logic [11:0] col = 12'h000;
  logic [2:0] acnt = 3'h0;
  logic [2:0] idx = 3'h0;
  logic fail = 1'b0;
  int tok = 0;
  wire logic [7:0] stat;
  // status byte: protect, ready, pass or fail
  assign stat = {write_prot_n, 1'b0, done_line_n, 4'h0, fail};
  initial
  begin
    done_line_n = 1'b1;
    byte_drive = 8'h00;
    foreach (mem[i]) mem[i] = 8'hFF;
  end
  // busy spell; a later command cuts an earlier spell short
  task automatic go_busy(input int ns);
    int k;
    done_line_n = 1'b0;
    tok++;
    k = tok;
    fork
      #(ns) if (k == tok) done_line_n = 1'b1;
    join_none
  endtask : go_busy
  // capture on the write strobe rise
  always @(posedge write_strobe_n)
    if (!chip_en_n && cmd_latch)
      case (byte_port)
        CMD_READ_SETUP: {mode, acnt} = {M_READ, 3'h0};
        CMD_READ_START: go_busy(READ_NS);
        CMD_DATA_IN: {mode, acnt} = {M_PROG, 3'h0};
        CMD_PROG_CONFIRM: if (write_prot_n) {fail, tok} = {fail_en, tok};
        CMD_ERASE_SETUP: acnt = 3'h0;
        CMD_ERASE_CONFIRM: if (write_prot_n)
          foreach (mem[i]) {mem[i], fail} = {8'hFF, fail_en};
        CMD_ID_READ: {mode, idx} = {M_ID, 3'h0};
        CMD_STATUS: mode = M_STAT;
        CMD_RESET: mode = M_IDLE;
        default: ;
      endcase
    else if (!chip_en_n && addr_latch)
    begin
      if (acnt == 3'h0) col[7:0] = byte_port;
      if (acnt == 3'h1) col[11:8] = byte_port[3:0];
      acnt++;
    end
    else if (!chip_en_n && mode == M_PROG && write_prot_n)
      {mem[col[5:0]], col} = {byte_port, col + 12'h001};
  // busy spells started by confirm and abort commands
  always @(posedge write_strobe_n)
    if (!chip_en_n && cmd_latch && byte_port == CMD_PROG_CONFIRM
      && write_prot_n) go_busy(PROG_NS);
    else if (!chip_en_n && cmd_latch && byte_port == CMD_ERASE_CONFIRM
      && write_prot_n) go_busy(ERASE_NS);
    else if (!chip_en_n && cmd_latch && byte_port == CMD_RESET)
      go_busy(200);
  // output on the read strobe fall, column steps by one in read mode
  always @(negedge read_strobe_n)
    if (!chip_en_n)
      case (mode)
        M_READ: {byte_drive, col} = {mem[col[5:0]], col + 12'h001};
        M_ID: {byte_drive, idx} = {idx == 3'h0 ? ID0 : idx == 3'h1 ? ID1 :
          idx == 3'h2 ? ID2 : idx == 3'h3 ? ID3 : ID4, idx + 3'h1};
        M_STAT: byte_drive = stat;
        default: byte_drive = ~byte_drive;
      endcase
endmodule : ncu_flash_model
`default_nettype wire

// ===== ncu_ctrl_bench.sv
// bench: register-level tests of the nand host controller with a flash model
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    checks++; \
    if ((got) !== (ex)) \
    begin \
      n_mismatch++; \
      $display("unexpected %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module ncu_ctrl_bench
  import ncu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // two chips; 4 KB page, 16 spare, 256 KB block, x8; 2 planes of 512 Mbit
  localparam logic [7:0] F2 = {4'h0, 2'b00, 2'b01};
  localparam logic [7:0] F3 = {2'b00, 2'b10, 2'b01, 2'b10};
  localparam logic [7:0] F4 = {1'b0, 3'b011, 2'b01, 2'b00};
  typedef struct {logic [11:0] c; logic [11:0] n; logic [7:0] b;
    logic [7:0] st;} ncu_row_type;
  ncu_row_type rows [3] = '{'{12'h000, 12'h001, 8'h11, 8'hA0},
    '{12'h005, 12'h004, 8'hA0, 8'hA0}, '{12'h03C, 12'h004, 8'h3C, 8'hA0}};
  logic REF_CLK = 1'b0;
  logic RST = 1'b1;
  logic [2:0] a = 3'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic fail_en = 1'b0;
  logic [31:0] q;
  time t0;
  int checks = 0;
  int n_mismatch = 0;
  wire logic [31:0] rdat;
  wire logic wait_req, cle, ale, ce_n, we_n, rs_n, wp_n, oe, done_n;
  wire logic [7:0] bout, mdrv, bport;
  // wire level of the shared byte port
  assign bport = oe ? bout : mdrv;
  ncu_ctrl #(.COUNT_W(12)) DUT (.REF_CLK(REF_CLK), .RST(RST),
    .AVS_ADDRESS(a), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd),
    .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_req), .CMD_LATCH(cle),
    .ADDR_LATCH(ale), .CHIP_EN_N(ce_n), .WRITE_STROBE_N(we_n),
    .READ_STROBE_N(rs_n), .WRITE_PROT_N(wp_n), .BYTE_PORT_IN(bport),
    .BYTE_PORT_OUT(bout), .BYTE_PORT_OE(oe), .DONE_LINE_N(done_n));
  ncu_flash_model #(.ID2(F2), .ID3(F3), .ID4(F4)) flash (.chip_en_n(ce_n),
    .cmd_latch(cle), .addr_latch(ale), .write_strobe_n(we_n),
    .read_strobe_n(rs_n), .write_prot_n(wp_n), .byte_port(bport),
    .byte_drive(mdrv), .done_line_n(done_n), .fail_en(fail_en));
  initial forever #20 REF_CLK = ~REF_CLK;
  task automatic wrap_up();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  // one bus transfer, held until waitrequest is seen low
  task automatic av(input logic w, input logic [2:0] ad, input int d);
    int k;
    @(posedge REF_CLK);
    {wr, rd, a, wd} <= {w, !w, ad, d};
    k = 0;
    // waitrequest and read data are both taken at the rising edge
    @(posedge REF_CLK);
    while (wait_req !== 1'b0 && k < 20000)
    begin
      @(posedge REF_CLK);
      k++;
    end
    if (k >= 20000) `CHK("bus wait", 0, k)
    if (k >= 20000) wrap_up();
    q = rdat;
    {wr, rd} <= 2'b00;
  endtask : av
  task automatic poll();
    int k;
    q = 32'h8;
    for (k = 0; q[3] !== 1'b0 && k < 3000; k++) av(1'b0, ADDR_CTRL, 0);
    if (k >= 3000) `CHK("busy poll", 0, k)
    if (k >= 3000) wrap_up();
  endtask : poll
  task automatic go(input logic [11:0] c, n, input logic [2:0] op);
    av(1'b1, ADDR_COLUMN, c);
    av(1'b1, ADDR_PAGE, 3);
    av(1'b1, ADDR_COUNT, n);
    av(1'b1, ADDR_CTRL, op);
  endtask : go
  task automatic xfer(input logic [11:0] c, n, input logic [7:0] b, s,
    input logic w);
    go(c, n, w ? OP_PROG : OP_READ);
    for (int i = 0; i < n; i++)
    begin
      av(w, w ? ADDR_WDATA : ADDR_RDATA, b + s * 8'(i));
      if (!w) `CHK("read byte", b + s * 8'(i), q[7:0])
    end
    poll();
  endtask : xfer
  task automatic stat();
    av(1'b1, ADDR_CTRL, OP_STATUS);
    poll();
    av(1'b0, ADDR_STATUS, 0);
  endtask : stat
  initial
  begin
    repeat (12) @(posedge REF_CLK);
    RST <= 1'b0;
    `CHK("idle pins", 3'b110, {ce_n, we_n, wp_n})
    stat();
    `CHK("status protected", 8'h20, q[7:0])
    av(1'b1, ADDR_STATUS, 32'h0000_0080);
    av(1'b1, ADDR_CTRL, OP_ID);
    poll();
    av(1'b0, ADDR_IDLO, 0);
    `CHK("id bytes", {8'h5A, 8'hC3, F2, F3}, q)
    av(1'b0, ADDR_STATUS, 0);
    `CHK("id byte 5", F4, q[31:24])
    foreach (rows[r])
    begin
      xfer(rows[r].c, rows[r].n, rows[r].b, 8'h01, 1'b1);
      xfer(rows[r].c, rows[r].n, rows[r].b, 8'h01, 1'b0);
      stat();
      `CHK("status", rows[r].st, q[7:0])
    end
    av(1'b1, ADDR_CTRL, OP_ERASE);
    poll();
    xfer(12'h005, 12'h004, 8'hFF, 8'h00, 1'b0);
    fail_en <= 1'b1;
    xfer(12'h010, 12'h001, 8'h77, 8'h01, 1'b1);
    stat();
    `CHK("status fail", 8'hA1, q[7:0])
    av(1'b1, ADDR_CTRL, OP_ERASE);
    // let the erase confirm go out so the abort cuts a busy spell
    repeat (30) @(posedge REF_CLK);
    t0 = $time;
    av(1'b1, ADDR_CTRL, OP_RESET);
    poll();
    `CHK("abort time", 1'b1, 1'($time - t0 < 10000))
    wrap_up();
  end
endmodule : ncu_ctrl_bench
`default_nettype wire
